// *** logic/ppfm_cfg.svh ***
/*
 * Register offsets, field positions, reset values and pin masks of the port pin function mux.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef PPFM_CFG_SVH
`define PPFM_CFG_SVH

`define PPFM_NPORT 10
`define PPFM_IDX_P12 4'h8
`define PPFM_IDX_P13 4'h9

`define PPFM_GRP_LATCH 2'h0
`define PPFM_GRP_DIR 2'h1
`define PPFM_GRP_PIN 2'h2

`define PPFM_OFS_LOW_PULLUP_OPTION_REGISTER 8'hc0
`define PPFM_OFS_HIGH_PULLUP_OPTION_REGISTER 8'hc4
`define PPFM_OFS_MM 8'hc8
`define PPFM_OFS_ANALOG 8'hcc
`define PPFM_OFS_EDGE 8'hd0
`define PPFM_OFS_CTRL 8'hd4
`define PPFM_OFS_RTBUF 8'hd8
`define PPFM_OFS_STATUS 8'hdc
`define PPFM_OFS_MASK 8'he0

`define PPFM_MM_EXP 0
`define PPFM_MM_WAIT 1
`define PPFM_MM_P4OUT 2
`define PPFM_CTRL_RT 0
`define PPFM_CTRL_DACA 1
`define PPFM_CTRL_DACB 2
`define PPFM_STAT_P4FALL 7

`define PPFM_DIR_RST 8'hff
`define PPFM_REG_RST 8'h00
`define PPFM_EDGE_RST 14'h0000
`define PPFM_MASK_P7 8'h07
`define PPFM_MASK_P13 8'h03
`define PPFM_MASK_P0_OUT 8'h7e
`define PPFM_MASK_P6_OD 8'h0f
`define PPFM_MASK_P6_HI 8'hf0

`define PPFM_RESP_OKAY 2'h0
`define PPFM_RESP_SLVERR 2'h2

`endif

// *** logic/ppfm_pkg.sv ***
/*
 * Types shared by the port pin function mux.
 * Assumes nothing of its surroundings.
 */
package ppfm_pkg;
    typedef logic [7:0] ppfm_port_t;
    typedef logic [9:0][7:0] ppfm_port_arr_t;
endpackage : ppfm_pkg

// *** logic/ppfm_top.sv ***
/*
 * Port pin function mux: direction, output latch, pull-up and alternate
 * function selection for ports 0..7, 12 and 13, with an AXI4-Lite slave.
 * Assumes pins sampled synchronously to ref_clk; array index 8 is port 12,
 * index 9 is port 13. Pad drivers resolve pin_out/pin_oe into the wire.
 */
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
// How it works
// - Port 0 bits 0,7 input only.
// - Per-bit direction on bidirectional ports.
// - Low pull-up option, input pins only.
// - Ports 12,13 use high pull-up option.
// - Analog-selected port 1 pins lose pull-up.
// - Port 4 direction set as a byte.
// - Port 4 falling edge sets flag.
// - Expansion mode: port 4 address/data, pull-ups off.
// - Expansion mode: port 5 high address, pull-ups off.
// - Expansion mode: port 6 strobes, pull-ups off.
// - Port 6 low nibble open drain.
// - Unused wait pin stays ordinary port bit.
// - External interrupts on rising, falling or both.
// - Interrupt 0/1 edge triggers timer capture.
// - Port 12 real-time output updates on trigger.
// - Low system reset pin resets the register file; AXI handshake state is kept.
`timescale 1ns/1ps
`include "ppfm_cfg.svh"

module ppfm_top
    import ppfm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ppfm_port_arr_t pin_in,
    output ppfm_port_arr_t pin_out,
    output ppfm_port_arr_t pin_oe,
    output ppfm_port_arr_t pullup_en,
    input wire logic [7:0] xbus_ad_out,
    input wire logic xbus_ad_oe,
    input wire logic [7:0] xbus_addr_high,
    input wire logic xbus_rd_n,
    input wire logic xbus_wr_n,
    input wire logic xbus_address_latch_strobe,
    output logic [7:0] xbus_ad_in,
    output logic xbus_wait_n,
    input wire logic rt_trigger,
    output logic [6:0] ext_int_req,
    output logic timer16_capture_trigger,
    output logic irq
);

    ppfm_port_t latch_q [`PPFM_NPORT];
    ppfm_port_t dir_q [`PPFM_NPORT];
    logic [7:0] low_pullup_option_register_q;
    logic [7:0] high_pullup_option_register_q;
    logic [7:0] mm_q;
    logic [7:0] analog_q;
    logic [13:0] edge_q;
    logic [7:0] ctrl_q;
    logic [7:0] rtbuf_q;
    logic [7:0] rt_out_q;
    logic [7:0] status_q;
    logic [7:0] mask_q;
    logic [7:0] prev_p0;
    logic [7:0] prev_p4;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    ppfm_port_arr_t next_out;
    ppfm_port_arr_t next_oe;
    ppfm_port_arr_t next_pu;
    wire logic soft_rst = ~reset_pin_n;
    wire logic exp_mode = mm_q[`PPFM_MM_EXP];
    wire logic wait_used = mm_q[`PPFM_MM_WAIT];

    // Register read: {hit, data}
    function automatic logic [32:0] rd_word(input logic [7:0] a);
        logic [3:0] idx;
        logic [32:0] r;
        idx = a[5:2];
        r = {1'b0, 32'h0000_0000};
        if (a[7:6] != 2'h3) begin
            if (idx < 4'(`PPFM_NPORT)) begin
                r[32] = 1'b1;
                case (a[7:6])
                    `PPFM_GRP_LATCH: r[7:0] = latch_q[idx];
                    `PPFM_GRP_DIR: r[7:0] = dir_q[idx];
                    default: r[7:0] = pin_in[idx];
                endcase
            end
        end else begin
            r[32] = 1'b1;
            case (a)
                `PPFM_OFS_LOW_PULLUP_OPTION_REGISTER: r[7:0] = low_pullup_option_register_q;
                `PPFM_OFS_HIGH_PULLUP_OPTION_REGISTER: r[7:0] = high_pullup_option_register_q;
                `PPFM_OFS_MM: r[7:0] = mm_q;
                `PPFM_OFS_ANALOG: r[7:0] = analog_q;
                `PPFM_OFS_EDGE: r[13:0] = edge_q;
                `PPFM_OFS_CTRL: r[7:0] = ctrl_q;
                `PPFM_OFS_RTBUF: r[7:0] = rtbuf_q;
                `PPFM_OFS_STATUS: r[7:0] = status_q;
                `PPFM_OFS_MASK: r[7:0] = mask_q;
                default: r[32] = 1'b0;
            endcase
        end
        return r;
    endfunction : rd_word

    // Bus decode
    wire logic aw_take = s_axi_awvalid & s_axi_awready;
    wire logic w_take = s_axi_wvalid & s_axi_wready;
    wire logic do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
    wire logic b_done = s_axi_bvalid & s_axi_bready;
    wire logic ar_take = s_axi_arvalid & s_axi_arready;
    wire logic r_done = s_axi_rvalid & s_axi_rready;
    wire logic [32:0] wr_old = rd_word(aw_addr_q);
    wire logic [32:0] rd_now = rd_word(s_axi_araddr);
    wire logic [31:0] wr_bmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                                  {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wire logic [31:0] wr_val = (wr_old[31:0] & ~wr_bmask) | (w_data_q & wr_bmask);
    wire logic [3:0] wr_idx = aw_addr_q[5:2];
    wire logic wr_port = do_write & wr_old[32] & (aw_addr_q[7:6] != 2'h3);
    wire logic wr_ctl = do_write & (aw_addr_q[7:6] == 2'h3);
    wire logic stat_rd = ar_take & (s_axi_araddr == `PPFM_OFS_STATUS);

    // Edge detection on port 0 interrupt inputs and port 4
    logic [6:0] edge_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_int
            wire logic rise = pin_in[0][gi] & ~prev_p0[gi];
            wire logic fall = ~pin_in[0][gi] & prev_p0[gi];
            assign edge_hit[gi] = (edge_q[2*gi] & rise) | (edge_q[2*gi+1] & fall);
        end
    endgenerate
    wire logic p4_fall = |(~pin_in[4] & prev_p4);
    wire logic [7:0] events = {p4_fall, edge_hit};
    wire logic [7:0] next_status = (status_q & ~{8{stat_rd}}) | events;

    // Per-port pin function selection
    generate
        for (gi = 0; gi < `PPFM_NPORT; gi++) begin : g_port
            localparam logic [7:0] PMASK = (gi == 7) ? `PPFM_MASK_P7 :
                                           ((gi == 9) ? `PPFM_MASK_P13 : 8'hff);
            localparam logic [7:0] OMASK = (gi == 0) ? `PPFM_MASK_P0_OUT : PMASK;
            wire logic [7:0] in_m = (gi == 4) ? {8{~mm_q[`PPFM_MM_P4OUT]}} : dir_q[gi];
            wire logic pu_sel = (gi < 8) ? low_pullup_option_register_q[gi % 8] : high_pullup_option_register_q[gi % 2];
            logic [7:0] o;
            logic [7:0] e;
            logic [7:0] u;
            always_comb begin
                o = latch_q[gi];
                e = ~in_m & OMASK;
                u = in_m & OMASK & {8{pu_sel}};
                if (gi == 1) begin
                    u = u & ~analog_q;
                end
                if (gi == 4 && exp_mode) begin
                    o = xbus_ad_out;
                    e = {8{xbus_ad_oe}};
                    u = 8'h00;
                end
                if (gi == 5 && exp_mode) begin
                    o = xbus_addr_high;
                    e = 8'hff;
                    u = 8'h00;
                end
                if (gi == 6) begin
                    u = u & `PPFM_MASK_P6_HI;
                    o = o & `PPFM_MASK_P6_HI;
                    e = (e & `PPFM_MASK_P6_HI) | (~in_m & ~latch_q[gi] & `PPFM_MASK_P6_OD);
                    if (exp_mode) begin
                        o[4] = xbus_rd_n;
                        o[5] = xbus_wr_n;
                        o[7] = xbus_address_latch_strobe;
                        e = e | 8'hb0;
                        u = u & 8'h4f;
                        if (wait_used) begin
                            e[6] = 1'b0;
                            u[6] = 1'b0;
                        end
                    end
                end
                if (gi == 8 && ctrl_q[`PPFM_CTRL_RT]) begin
                    o = rt_out_q;
                    e = 8'hff;
                    u = 8'h00;
                end
                if (gi == 9) begin
                    e = e & ~{6'h00, ctrl_q[`PPFM_CTRL_DACB], ctrl_q[`PPFM_CTRL_DACA]};
                    u = u & ~{6'h00, ctrl_q[`PPFM_CTRL_DACB], ctrl_q[`PPFM_CTRL_DACA]};
                end
            end
            assign next_out[gi] = o & PMASK;
            assign next_oe[gi] = e & PMASK;
            assign next_pu[gi] = u;
        end
    endgenerate

    // Pin drivers and alternate-function outputs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_out <= '0;
            pin_oe <= '0;
            pullup_en <= '0;
            xbus_ad_in <= 8'h00;
            xbus_wait_n <= 1'b1;
            ext_int_req <= 7'h00;
            timer16_capture_trigger <= 1'b0;
            irq <= 1'b0;
            prev_p0 <= 8'h00;
            prev_p4 <= 8'h00;
        end else begin
            pin_out <= next_out;
            pin_oe <= next_oe;
            pullup_en <= next_pu;
            xbus_ad_in <= pin_in[4];
            xbus_wait_n <= ~wait_used | pin_in[6][6];
            ext_int_req <= edge_hit;
            timer16_capture_trigger <= edge_hit[0] | edge_hit[1];
            irq <= |(next_status & mask_q);
            prev_p0 <= pin_in[0];
            prev_p4 <= pin_in[4];
        end
    end

    // AXI4-Lite handshakes, one write and one read at a time
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PPFM_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `PPFM_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_old[32] ? `PPFM_RESP_OKAY : `PPFM_RESP_SLVERR;
            end
            if (b_done) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (ar_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_now[31:0];
                s_axi_rresp <= rd_now[32] ? `PPFM_RESP_OKAY : `PPFM_RESP_SLVERR;
            end
            if (r_done) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Register file; a low reset pin clears it like the reset input
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `PPFM_NPORT; i++) begin
                latch_q[i] <= `PPFM_REG_RST;
                dir_q[i] <= `PPFM_DIR_RST;
            end
            low_pullup_option_register_q <= `PPFM_REG_RST;
            high_pullup_option_register_q <= `PPFM_REG_RST;
            mm_q <= `PPFM_REG_RST;
            analog_q <= `PPFM_REG_RST;
            edge_q <= `PPFM_EDGE_RST;
            ctrl_q <= `PPFM_REG_RST;
            rtbuf_q <= `PPFM_REG_RST;
            rt_out_q <= `PPFM_REG_RST;
            status_q <= `PPFM_REG_RST;
            mask_q <= `PPFM_REG_RST;
        end else if (soft_rst) begin
            for (int i = 0; i < `PPFM_NPORT; i++) begin
                latch_q[i] <= `PPFM_REG_RST;
                dir_q[i] <= `PPFM_DIR_RST;
            end
            low_pullup_option_register_q <= `PPFM_REG_RST;
            high_pullup_option_register_q <= `PPFM_REG_RST;
            mm_q <= `PPFM_REG_RST;
            analog_q <= `PPFM_REG_RST;
            edge_q <= `PPFM_EDGE_RST;
            ctrl_q <= `PPFM_REG_RST;
            rtbuf_q <= `PPFM_REG_RST;
            rt_out_q <= `PPFM_REG_RST;
            status_q <= `PPFM_REG_RST;
            mask_q <= `PPFM_REG_RST;
        end else begin
            status_q <= next_status;
            if (rt_trigger) begin
                rt_out_q <= rtbuf_q;
            end
            if (wr_port && aw_addr_q[7:6] == `PPFM_GRP_LATCH) begin
                latch_q[wr_idx] <= wr_val[7:0];
            end
            if (wr_port && aw_addr_q[7:6] == `PPFM_GRP_DIR) begin
                dir_q[wr_idx] <= wr_val[7:0];
            end
            if (wr_ctl) begin
                case (aw_addr_q)
                    `PPFM_OFS_LOW_PULLUP_OPTION_REGISTER: low_pullup_option_register_q <= wr_val[7:0];
                    `PPFM_OFS_HIGH_PULLUP_OPTION_REGISTER: high_pullup_option_register_q <= wr_val[7:0];
                    `PPFM_OFS_MM: mm_q <= wr_val[7:0];
                    `PPFM_OFS_ANALOG: analog_q <= wr_val[7:0];
                    `PPFM_OFS_EDGE: edge_q <= wr_val[13:0];
                    `PPFM_OFS_CTRL: ctrl_q <= wr_val[7:0];
                    `PPFM_OFS_RTBUF: rtbuf_q <= wr_val[7:0];
                    `PPFM_OFS_MASK: mask_q <= wr_val[7:0];
                    default: ;
                endcase
            end
        end
    end

endmodule : ppfm_top

// *** tb/ppfm_monitor.sv ***
/* Checker on the pin mux outputs.
   Assumes binding to ppfm_top. */
`timescale 1ns/1ps
module ppfm_monitor
    import ppfm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire ppfm_port_arr_t pin_in,
    input wire ppfm_port_arr_t pin_out,
    input wire ppfm_port_arr_t pin_oe,
    input wire ppfm_port_arr_t pullup_en,
    input wire logic [7:0] xbus_ad_in,
    input wire logic xbus_wait_n,
    input wire logic [6:0] ext_int_req,
    input wire logic timer16_capture_trigger
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence sys_rst_s;
        !reset_pin_n ##1 1'b1;
    endsequence
    p0_input_only_a: assert property (pin_oe[0][0] == 1'b0 && pin_oe[0][7] == 1'b0)
        else $error("port0 end bit driven");
    unimpl_bits_a: assert property (pin_oe[7][7:3] == 5'h00 && pin_oe[9][7:2] == 6'h00)
        else $error("missing bit driven");
    pull_input_a: assert property ((pullup_en & pin_oe) == '0)
        else $error("pull-up on output");
    p4_byte_a: assert property (pin_oe[4] == 8'h00 || pin_oe[4] == 8'hff)
        else $error("port4 split direction");
    drain_a: assert property ((pin_out[6][3:0] & pin_oe[6][3:0]) == 4'h0 && pullup_en[6][3:0] == 4'h0)
        else $error("port6 low drives high");
    ad_in_a: assert property (xbus_ad_in == $past(pin_in[4]))
        else $error("bus input wrong");
    wait_pad_a: assert property (!xbus_wait_n |-> $past(pin_in[6][6]) == 1'b0)
        else $error("wait without pad low");
    cap_src_a: assert property (timer16_capture_trigger == (ext_int_req[0] | ext_int_req[1]))
        else $error("capture trigger wrong");
    edge_pulse_a: assert property ((ext_int_req & ~($past(pin_in[0][6:0]) ^ $past(pin_in[0][6:0], 2))) == 7'h00)
        else $error("pulse without pad edge");
    sys_reset_a: assert property (sys_rst_s |-> ##1 (pin_oe == '0 && pullup_en == '0))
        else $error("pins not idle after reset");
endmodule : ppfm_monitor

bind ppfm_top ppfm_monitor u_ppfm_monitor (.ref_clk, .rst, .reset_pin_n, .pin_in, .pin_out,
    .pin_oe, .pullup_en, .xbus_ad_in, .xbus_wait_n, .ext_int_req, .timer16_capture_trigger);

// *** tb/ppfm_board.sv ***
/* Board model: resolves each pad from chip and board drive.
   Assumes one driver per pad at a time. */
`timescale 1ns/1ps
module ppfm_board
    import ppfm_pkg::*;
(
    input wire logic ref_clk,
    input wire ppfm_port_arr_t pin_out,
    input wire ppfm_port_arr_t pin_oe,
    input wire ppfm_port_arr_t pullup_en,
    input wire ppfm_port_arr_t drv_val,
    input wire ppfm_port_arr_t drv_en,
    output ppfm_port_arr_t pin_in
);
    ppfm_port_arr_t last;
    ppfm_port_arr_t idle;
    // Undriven pad: pull-up level, else wanders
    assign idle = pullup_en | ~last;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_en & drv_val) | (~pin_oe & ~drv_en & idle);
    always_ff @(posedge ref_clk) begin
        last <= pin_in;
    end
endmodule : ppfm_board

// *** tb/port_pin_function_mux_tb.sv ***
/* Self-checking bench of the pin mux.
   Assumes ppfm_top, ppfm_board and the checker bind. */
`timescale 1ns/1ps
`include "ppfm_cfg.svh"
module port_pin_function_mux_tb;
    import ppfm_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, reset_pin_n = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rt_trigger = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, r, hi;
    ppfm_port_arr_t pin_in, pin_out, pin_oe, pullup_en, dir, lat, eo, drv_val = '0;
    logic [7:0] xbus_ad_out = 8'h00, xbus_addr_high = 8'h00, xbus_ad_in, lo, an, e8, p8;
    logic xbus_ad_oe = 1'b0, xbus_rd_n = 1'b1, xbus_wr_n = 1'b1, xbus_address_latch_strobe = 1'b0, p4;
    logic xbus_wait_n, timer16_capture_trigger;
    logic [6:0] ext_int_req;
    int n_errors = 0, total_checks = 0, cyc = 0, n_pulse = 0, n_cap = 0, seed = 35142;

    always #2.5 ref_clk = ~ref_clk;

    ppfm_top u_ppfm_top (.ref_clk, .rst, .reset_pin_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out, .pin_oe,
        .pullup_en, .xbus_ad_out, .xbus_ad_oe, .xbus_addr_high, .xbus_rd_n, .xbus_wr_n,
        .xbus_address_latch_strobe, .xbus_ad_in, .xbus_wait_n, .rt_trigger, .ext_int_req,
        .timer16_capture_trigger, .irq);
    ppfm_board u_ppfm_board (.ref_clk, .pin_out, .pin_oe, .pullup_en, .drv_val,
        .drv_en('1), .pin_in);

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (ext_int_req == 7'h7f) n_pulse <= n_pulse + 1;
        if (timer16_capture_trigger) n_cap <= n_cap + 1;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic chk_v(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk_v

    task automatic chk_a(input string nm, input ppfm_port_arr_t e, input ppfm_port_arr_t g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk_a

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    function automatic logic [7:0] f_msk(input int i);
        return (i == 0) ? 8'h7e : (i == 7) ? 8'h07 : (i == 9) ? 8'h03 : 8'hff;
    endfunction : f_msk

    function automatic ppfm_port_arr_t f_oe(input ppfm_port_arr_t dr, input ppfm_port_arr_t lt,
                                            input logic b);
        ppfm_port_arr_t o;
        for (int i = 0; i < 10; i++) o[i] = ~dr[i] & f_msk(i);
        o[4] = {8{b}};
        o[6][3:0] = ~dr[6][3:0] & ~lt[6][3:0];
        return o;
    endfunction : f_oe

    function automatic ppfm_port_arr_t f_pu(input ppfm_port_arr_t o, input logic [7:0] l,
                                            input logic [1:0] h, input logic [7:0] a);
        ppfm_port_arr_t u;
        for (int i = 0; i < 10; i++) u[i] = ~o[i] & f_msk(i) & {8{(i < 8) ? l[i] : h[i - 8]}};
        u[1] = u[1] & ~a;
        u[6] = u[6] & 8'hf0;
        return u;
    endfunction : f_pu

    initial begin
        tick(12);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(8'h40 + 8'(4 * i));
            chk_v("dir_rst", 8'hff, d[7:0]);
        end
        chk_a("oe_rst", '0, pin_oe);
        chk_a("pu_rst", '0, pullup_en);
        rd(8'hfc);
        chk_v("unmapped", 8'h02, {6'h0, r});
        wr(8'hfc, 32'h1);
        chk_v("unmapped_wr", 8'h02, {6'h0, r});
        $display("test reset done");
        for (int t = 0; t < 8; t++) begin
            for (int i = 0; i < 10; i++) begin
                dir[i] = (t == 7) ? 8'h00 : 8'($random(seed));
                lat[i] = 8'($random(seed));
                wr(8'(4 * i), {24'h0, lat[i]});
                wr(8'h40 + 8'(4 * i), {24'h0, dir[i]});
            end
            lo = (t == 6) ? 8'hff : 8'($random(seed));
            hi = 2'($random(seed));
            an = 8'($random(seed)) & dir[1];
            p4 = 1'($random(seed));
            wr(`PPFM_OFS_LOW_PULLUP_OPTION_REGISTER, {24'h0, lo});
            chk_v("bresp", 8'h00, {6'h0, r});
            wr(`PPFM_OFS_HIGH_PULLUP_OPTION_REGISTER, {30'h0, hi});
            wr(`PPFM_OFS_ANALOG, {24'h0, an});
            wr(`PPFM_OFS_MM, {29'h0, p4, 2'h0});
            tick(2);
            eo = f_oe(dir, lat, p4);
            chk_a("oe", eo, pin_oe);
            chk_a("out", lat & eo & ~(80'hf << 48), pin_out & eo);
            chk_a("pu", f_pu(eo, lo, hi, an), pullup_en);
        end
        $display("test config done");
        for (int i = 0; i < 10; i++) wr(8'h40 + 8'(4 * i), 32'hff);
        wr(`PPFM_OFS_LOW_PULLUP_OPTION_REGISTER, 32'hfe);
        for (int m = 1; m < 4; m += 2) begin
            wr(`PPFM_OFS_MM, m);
            xbus_addr_high <= 8'($random(seed));
            xbus_ad_out <= 8'($random(seed));
            xbus_ad_oe <= 1'b1;
            xbus_rd_n <= 1'b0;
            xbus_address_latch_strobe <= 1'b1;
            tick(3);
            chk_v("a_hi", xbus_addr_high, pin_out[5] & pin_oe[5]);
            chk_v("ad", xbus_ad_out, pin_out[4] & pin_oe[4]);
            chk_v("pu_bus", 8'h00, pullup_en[4] | pullup_en[5]);
            chk_v("strobe", 8'ha0, pin_out[6] & pin_oe[6] & 8'hb0);
            chk_v("pu_p6", (m == 1) ? 8'h40 : 8'h00, pullup_en[6]);
            chk_v("wait", {7'h0, m == 1}, {7'h0, xbus_wait_n});
        end
        xbus_ad_oe <= 1'b0;
        wr(`PPFM_OFS_MM, 0);
        $display("test expansion done");
        for (int m = 1; m < 4; m++) begin
            wr(`PPFM_OFS_EDGE, {18'h0, {7{m[1:0]}}});
            wr(`PPFM_OFS_MASK, (m == 3) ? 32'hff : 32'h0);
            rd(`PPFM_OFS_STATUS);
            n_pulse = 0;
            n_cap = 0;
            drv_val[0] <= 8'h7f;
            drv_val[4] <= 8'hff;
            tick(4);
            drv_val[0] <= 8'h00;
            drv_val[4] <= 8'h00;
            tick(4);
            chk_v("pulses", 8'((m & 1) + (m >> 1)), 8'(n_pulse));
            chk_v("capture", 8'((m & 1) + (m >> 1)), 8'(n_cap));
            chk_v("irq", {7'h0, m == 3}, {7'h0, irq});
            rd(`PPFM_OFS_STATUS);
            chk_v("status", 8'hff, d[7:0]);
            tick(2);
            chk_v("irq_clr", 8'h00, {7'h0, irq});
        end
        $display("test interrupts done");
        wr(`PPFM_OFS_CTRL, 32'h1);
        wr(8'h60, 32'h0);
        for (int k = 0; k < 2; k++) begin
            e8 = 8'($random(seed));
            wr(`PPFM_OFS_RTBUF, {24'h0, e8});
            tick(2);
            if (k == 1) chk_v("rt_hold", p8, pin_out[8]);
            rt_trigger <= 1'b1;
            tick(1);
            rt_trigger <= 1'b0;
            tick(2);
            chk_v("rt_out", e8, pin_out[8]);
            p8 = e8;
        end
        wr(8'h24, 32'h0);
        wr(8'h64, 32'h0);
        wr(`PPFM_OFS_CTRL, 32'h3);
        tick(2);
        chk_v("dac_oe", 8'h02, pin_oe[9]);
        chk_v("dac_out", 8'h00, pin_out[9]);
        $display("test realtime done");
        reset_pin_n <= 1'b0;
        tick(1);
        reset_pin_n <= 1'b1;
        tick(3);
        chk_a("oe_sys", '0, pin_oe);
        chk_a("pu_sys", '0, pullup_en);
        rd(8'h60);
        chk_v("dir_sys", 8'hff, d[7:0]);
        $display("test system reset done");
        print_verdict();
    end
endmodule : port_pin_function_mux_tb
